// ==== rtl/ptg_pkg.sv ====
// package: register map, field positions, constants and types of the test block
package ptg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_GEN0 = 5'h04;
  localparam logic [4:0] OFF_GEN1 = 5'h08;
  localparam logic [4:0] OFF_GOOD = 5'h0C;
  localparam logic [4:0] OFF_BAD = 5'h10;
  localparam logic [4:0] OFF_ISTAT = 5'h14;
  localparam logic [4:0] OFF_IMASK = 5'h18;
  localparam logic [4:0] OFF_STAT = 5'h1C;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int B_GEN_EN = 0;
  localparam int B_START = 1;
  localparam int B_CONT = 2;
  localparam int B_FCS_BAD = 3;
  localparam int B_ISOLATE = 4;
  localparam int B_FAR = 5;
  localparam int B_NEAR = 6;
  localparam int B_DIAG = 7;
  localparam int B_CONN = 8;
  localparam int B_SWAP_OFF = 9;
  localparam int B_ANEG = 10;
  localparam int B_DUPLEX = 11;
  localparam int B_SPEED = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_2C00;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // ----------------------------------------------------------------
  // generator configuration and counter fields
  // ----------------------------------------------------------------
  localparam int B_SRC = 0;
  localparam int B_DST = 8;
  localparam logic [31:0] GEN0_RST = 32'h0000_0201;
  localparam int B_LEN = 0;
  localparam int B_IPG = 16;
  localparam int B_PAT = 24;
  localparam logic [31:0] GEN1_RST = 32'hA50C_0040;
  localparam int B_RXFLAG = 15;
  localparam int GOOD_W = 14;
  localparam int BAD_W = 8;
  localparam logic [13:0] GOOD_MAX = 14'h270F;
  localparam logic [7:0] BAD_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // interrupt and status bits
  // ----------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int I_RXFRAME = 0;
  localparam int I_GENDONE = 1;
  localparam int I_BADCRC = 2;
  localparam int S_LINK = 0;
  localparam int S_GEN = 1;

  // ----------------------------------------------------------------
  // frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [7:0] LADMIN = 8'h02;
  localparam logic [10:0] FRM_OVH = 11'h012;
  localparam logic [10:0] PRE_LAST = 11'h007;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
  localparam int FRAME_LIMIT_DEF = 30_000_000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [7:0] d;
  } ptg_strm_type;

  typedef enum logic [2:0] {G_IDLE, G_PRE, G_DATA, G_FCS, G_GAP}
    ptg_gen_state_type;
  typedef enum logic [1:0] {R_IDLE, R_PRE, R_DATA} ptg_rx_state_type;

  function automatic logic [31:0] ptg_merge(logic [31:0] o, logic [31:0] n,
                                            logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction

endpackage

// ==== rtl/ptg_sync.sv ====
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module ptg_sync
  import ptg_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // ptg_sync
`default_nettype wire

// ==== rtl/ptg_crc32.sv ====
// byte-wide frame check sequence register, reflected polynomial
`timescale 1ns/1ns
`default_nettype none
module ptg_crc32
  import ptg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control and data
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] d,
  output logic [31:0] crc
);
  function automatic logic [31:0] step(logic [31:0] c, logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      crc <= CRC_INIT;
    else if (init)
      crc <= CRC_INIT;
    else if (en)
      crc <= step(crc, d);
  end
endmodule // ptg_crc32
`default_nettype wire

// ==== rtl/ptg_top.sv ====
// packet generator, frame check counters and loopback paths of the phy
// Behaviour
// - with the generator enabled and neither loopback set, media transmit comes only from it.
// - receive outputs to the mac stay driven unless isolate is set.
// - setting start makes the generator send frames from its config.
// - config gives addresses, length, gap, fcs state, duration, pattern.
// - without continuous mode, start clears itself after the frame limit.
// - a 14-bit good-crc counter and an 8-bit bad-crc counter exist.
// - each received frame sets a flag and bumps exactly one counter.
// - reading a counter clears it.
// - the good counter wraps from 9999 to zero.
// - the bad counter saturates at 255.
// - far-end loopback sends received media data back to the media.
// - far-end loopback also feeds the mac and ignores mac transmit.
// - near-end loopback returns mac transmit to mac and sends nothing.
// - negotiation, speed and duplex settings hold in connector loopback.
// - diagnostics drop a 10/100 link and leave a gigabit link alone.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ptg_top
  import ptg_pkg::*;
#(
  parameter int FRAME_LIMIT = FRAME_LIMIT_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [4:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // mac side
  input wire ptg_strm_type macTx,
  output ptg_strm_type macRx,
  output logic macRxOe,
  // media side, sampled on the rising link clock edges
  input wire logic linkClk,
  input wire ptg_strm_type mediaRx,
  input wire logic linkOk,
  output ptg_strm_type mediaTx,
  // line configuration and status
  output logic linkUp,
  output logic anegEn,
  output logic [1:0] speedSel,
  output logic fullDuplex,
  output logic connLoop,
  output logic pairSwapOff,
  // interrupt
  output logic irq
);
  localparam int FC_W = $clog2(FRAME_LIMIT + 1);

  logic [31:0] ctrl_q, gen0_q, gen1_q, rdData;
  logic [IRQ_W-1:0] istat_q, imask_q, iev;
  logic [GOOD_W-1:0] goodCnt_q, goodBase;
  logic [BAD_W-1:0] badCnt_q, badBase;
  logic rxFlag_q, busReq, wrAcc, rdAcc, wrCtrl;
  logic rdGood, rdBad, rdStat;
  logic [4:0] adr;
  logic lcS, lcPrev_q, linkEdge, linkOkS;
  ptg_strm_type mRx, mTx, gOut_q;
  ptg_gen_state_type gst_q;
  ptg_rx_state_type rst_q;
  logic [10:0] gcnt_q, genLen, payLen;
  logic [7:0] dataByte, fcsByte;
  logic [31:0] gCrc, rCrc;
  logic [FC_W-1:0] frameCnt_q;
  logic genRun, frameSent, genDone, frameEnd, goodEv, badEv;

  // ----------------------------------------------------------------
  // input synchronisers and link clock edge
  // ----------------------------------------------------------------
  ptg_sync #(.W(20)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .d({linkClk, linkOk, mediaRx, macTx}),
    .q({lcS, linkOkS, mRx, mTx})
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      lcPrev_q <= 1'b0;
    else
      lcPrev_q <= lcS;
  end
  assign linkEdge = lcS & ~lcPrev_q;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  assign adr = {wbAdr[4:2], 2'b00};
  assign busReq = wbCyc & wbStb & ~wbAck;
  assign wrAcc = busReq & wbWe;
  assign rdAcc = busReq & ~wbWe;
  assign wrCtrl = wrAcc && adr == OFF_CTRL;
  assign rdGood = rdAcc && adr == OFF_GOOD;
  assign rdBad = rdAcc && adr == OFF_BAD;
  assign rdStat = rdAcc && adr == OFF_ISTAT;

  always_comb
  begin
    rdData = 32'h0000_0000;
    case (adr)
      OFF_CTRL: rdData = ctrl_q;
      OFF_GEN0: rdData = gen0_q;
      OFF_GEN1: rdData = gen1_q;
      OFF_GOOD: rdData = {16'h0000, rxFlag_q, 1'b0, goodCnt_q};
      OFF_BAD: rdData = {24'h00_0000, badCnt_q};
      OFF_ISTAT: rdData = {29'h0000_0000, istat_q};
      OFF_IMASK: rdData = {29'h0000_0000, imask_q};
      OFF_STAT: rdData = {30'h0000_0000, gst_q != G_IDLE, linkUp};
      default: rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
    end
    else
    begin
      wbAck <= busReq;
      wbDatR <= rdAcc ? rdData : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_q <= CTRL_RST;
    else if (wrCtrl)
      ctrl_q <= ptg_merge(ctrl_q, wbDatW, wbSel);
    else if (genDone)
      ctrl_q[B_START] <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen0_q <= GEN0_RST;
      gen1_q <= GEN1_RST;
      imask_q <= '0;
    end
    else if (wrAcc)
    begin
      if (adr == OFF_GEN0)
        gen0_q <= ptg_merge(gen0_q, wbDatW, wbSel);
      if (adr == OFF_GEN1)
        gen1_q <= ptg_merge(gen1_q, wbDatW, wbSel);
      if (adr == OFF_IMASK && wbSel[0])
        imask_q <= wbDatW[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // packet generator
  // ----------------------------------------------------------------
  assign genRun = ctrl_q[B_GEN_EN] & ctrl_q[B_START];
  assign genLen = gen1_q[B_LEN +: 11];
  assign payLen = genLen - FRM_OVH;
  assign frameSent = linkEdge && gst_q == G_FCS && gcnt_q == 11'h003;
  assign genDone = frameSent && !ctrl_q[B_CONT] &&
                   frameCnt_q == FC_W'(FRAME_LIMIT - 1);

  // header bytes: locally administered addresses, then length field
  always_comb
  begin
    dataByte = gen1_q[B_PAT +: 8];
    if (gcnt_q < 11'h006)
      dataByte = gcnt_q == 11'h000 ? LADMIN :
                 gcnt_q == 11'h005 ? gen0_q[B_DST +: 8] : 8'h00;
    else if (gcnt_q < 11'h00C)
      dataByte = gcnt_q == 11'h006 ? LADMIN :
                 gcnt_q == 11'h00B ? gen0_q[B_SRC +: 8] : 8'h00;
    else if (gcnt_q == 11'h00C)
      dataByte = {5'h00, payLen[10:8]};
    else if (gcnt_q == 11'h00D)
      dataByte = payLen[7:0];
  end

  // fcs sent low byte first; the bad option inverts it
  always_comb
  begin
    fcsByte = ~gCrc[8*gcnt_q[1:0] +: 8];
    if (ctrl_q[B_FCS_BAD])
      fcsByte = ~fcsByte;
  end

  ptg_crc32 uGenCrc (
    .clk(clk),
    .arst_n(arst_n),
    .init(gst_q == G_PRE),
    .en(linkEdge && gst_q == G_DATA),
    .d(dataByte),
    .crc(gCrc)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gst_q <= G_IDLE;
      gcnt_q <= 11'h000;
      gOut_q <= '0;
    end
    else if (linkEdge)
    begin
      case (gst_q)
        G_IDLE:
        begin
          gOut_q <= '0;
          gcnt_q <= 11'h000;
          if (genRun)
            gst_q <= G_PRE;
        end
        G_PRE:
        begin
          gOut_q <= {1'b1, gcnt_q == PRE_LAST ? SFD_BYTE : PRE_BYTE};
          gcnt_q <= gcnt_q == PRE_LAST ? 11'h000 : gcnt_q + 11'h001;
          if (gcnt_q == PRE_LAST)
            gst_q <= G_DATA;
        end
        G_DATA:
        begin
          gOut_q <= {1'b1, dataByte};
          gcnt_q <= gcnt_q + 11'h001;
          if (gcnt_q == genLen - 11'h005)
          begin
            gst_q <= G_FCS;
            gcnt_q <= 11'h000;
          end
        end
        G_FCS:
        begin
          gOut_q <= {1'b1, fcsByte};
          gcnt_q <= gcnt_q + 11'h001;
          if (gcnt_q == 11'h003)
          begin
            gst_q <= G_GAP;
            gcnt_q <= 11'h000;
          end
        end
        G_GAP:
        begin
          gOut_q <= '0;
          gcnt_q <= gcnt_q + 11'h001;
          if (gcnt_q >= {3'h0, gen1_q[B_IPG +: 8]})
            gst_q <= G_IDLE;
        end
        default:
          gst_q <= G_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      frameCnt_q <= '0;
    else if (!ctrl_q[B_START] || genDone)
      frameCnt_q <= '0;
    else if (frameSent)
      frameCnt_q <= frameCnt_q + FC_W'(1);
  end

  // ----------------------------------------------------------------
  // data path selection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mediaTx <= '0;
      macRx <= '0;
      macRxOe <= 1'b0;
    end
    else
    begin
      macRxOe <= !ctrl_q[B_ISOLATE];
      if (linkEdge)
      begin
        if (ctrl_q[B_NEAR])
          mediaTx <= '0;
        else if (ctrl_q[B_FAR])
          mediaTx <= mRx;
        else if (ctrl_q[B_GEN_EN])
          mediaTx <= gOut_q;
        else
          mediaTx <= mTx;
        if (ctrl_q[B_ISOLATE])
          macRx <= '0;
        else if (ctrl_q[B_NEAR])
          macRx <= mTx;
        else
          macRx <= mRx;
      end
    end
  end

  // ----------------------------------------------------------------
  // line configuration, diagnostics link drop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      linkUp <= 1'b0;
      anegEn <= 1'b0;
      speedSel <= 2'h0;
      fullDuplex <= 1'b0;
      connLoop <= 1'b0;
      pairSwapOff <= 1'b0;
    end
    else
    begin
      linkUp <= linkOkS && !(ctrl_q[B_DIAG] &&
                ctrl_q[B_SPEED +: 2] != SPD_1000);
      anegEn <= ctrl_q[B_ANEG];
      speedSel <= ctrl_q[B_SPEED +: 2];
      fullDuplex <= ctrl_q[B_DUPLEX];
      connLoop <= ctrl_q[B_CONN];
      pairSwapOff <= ctrl_q[B_SWAP_OFF] & connLoop;
    end
  end

  // ----------------------------------------------------------------
  // receive frame checker
  // ----------------------------------------------------------------
  assign frameEnd = linkEdge && rst_q == R_DATA && !mRx.en;
  assign goodEv = frameEnd && rCrc == CRC_RESIDUE;
  assign badEv = frameEnd && rCrc != CRC_RESIDUE;

  ptg_crc32 uRxCrc (
    .clk(clk),
    .arst_n(arst_n),
    .init(linkEdge && rst_q != R_DATA),
    .en(linkEdge && rst_q == R_DATA && mRx.en),
    .d(mRx.d),
    .crc(rCrc)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_q <= R_IDLE;
    else if (linkEdge)
    begin
      case (rst_q)
        R_IDLE:
          if (mRx.en)
            rst_q <= mRx.d == SFD_BYTE ? R_DATA : R_PRE;
        R_PRE:
          if (!mRx.en)
            rst_q <= R_IDLE;
          else if (mRx.d == SFD_BYTE)
            rst_q <= R_DATA;
        R_DATA:
          if (!mRx.en)
            rst_q <= R_IDLE;
        default:
          rst_q <= R_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // crc counters, clear on read, event after clear
  // ----------------------------------------------------------------
  assign goodBase = rdGood ? '0 : goodCnt_q;
  assign badBase = rdBad ? '0 : badCnt_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      goodCnt_q <= '0;
      badCnt_q <= '0;
      rxFlag_q <= 1'b0;
    end
    else
    begin
      if (goodEv)
        goodCnt_q <= goodBase == GOOD_MAX ? '0 : goodBase + 14'h0001;
      else
        goodCnt_q <= goodBase;
      if (badEv && badBase != BAD_MAX)
        badCnt_q <= badBase + 8'h01;
      else
        badCnt_q <= badBase;
      rxFlag_q <= frameEnd | (rxFlag_q & ~rdGood);
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign iev = {badEv, genDone, frameEnd};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      istat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      istat_q <= (rdStat ? '0 : istat_q) | iev;
      irq <= |(istat_q & imask_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_kick;
    linkEdge && gst_q == G_IDLE && genRun;
  endsequence
  sequence s_preamble;
    gst_q == G_PRE ##0 gcnt_q == 11'h000;
  endsequence
  property p_start;
    s_kick |=> s_preamble;
  endproperty
  a_start: assert property (p_start)
    else $error("generator did not start");

  property p_genSrc;
    linkEdge && ctrl_q[B_GEN_EN] && !ctrl_q[B_NEAR] && !ctrl_q[B_FAR]
      |=> mediaTx == $past(gOut_q);
  endproperty
  a_genSrc: assert property (p_genSrc)
    else $error("media transmit not from generator");

  property p_isolate;
    ctrl_q[B_ISOLATE] |=> !macRxOe ##1 (macRxOe == !ctrl_q[B_ISOLATE] ||
      $changed(ctrl_q));
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("receive enable wrong under isolate");

  property p_stopAtLimit;
    genDone && !wrCtrl |=> !ctrl_q[B_START] && frameCnt_q == '0;
  endproperty
  a_stopAtLimit: assert property (p_stopAtLimit)
    else $error("start not cleared at frame limit");

  property p_readClear;
    rdGood |=> wbAck && wbDatR[GOOD_W-1:0] == $past(goodCnt_q) &&
      goodCnt_q == ($past(goodEv) ? 14'h0001 : 14'h0000);
  endproperty
  a_readClear: assert property (p_readClear)
    else $error("good counter read did not clear");

  property p_wrap;
    goodEv && !rdGood && goodCnt_q == GOOD_MAX |=> goodCnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("good counter did not wrap");

  property p_saturate;
    badEv && !rdBad && badCnt_q == BAD_MAX |=> badCnt_q == BAD_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("bad counter did not saturate");

  property p_nearQuiet;
    linkEdge && ctrl_q[B_NEAR] |=> !mediaTx.en && macRx == $past(mTx) ||
      $past(ctrl_q[B_ISOLATE]);
  endproperty
  a_nearQuiet: assert property (p_nearQuiet)
    else $error("near loop sent to the network");

  property p_diagDrop;
    ctrl_q[B_DIAG] && ctrl_q[B_SPEED +: 2] != SPD_1000 |=> !linkUp;
  endproperty
  a_diagDrop: assert property (p_diagDrop)
    else $error("link held during diagnostics");

  property p_rxFlag;
    frameEnd |=> rxFlag_q && ($past(goodEv) ^ $past(badEv));
  endproperty
  a_rxFlag: assert property (p_rxFlag)
    else $error("received frame not flagged");

endmodule // ptg_top
`default_nettype wire

// ==== verification/ptg_link_partner.sv ====
// link partner model: byte clock, received frames and link state
`timescale 1ns/1ns
`default_nettype none
module ptg_link_partner
  import ptg_pkg::*;
(
  // media side
  output logic linkClk,
  output ptg_strm_type mediaRx,
  output logic linkOk
);
  logic [7:0] last;
  initial
  begin
    linkClk = 1'b0;
    linkOk = 1'b1;
    mediaRx = '0;
    last = 8'h00;
  end
  // byte clock runs free at 125 ns
  always
  begin
    #62 linkClk = 1'b1;
    #63 linkClk = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    @(negedge linkClk);
    mediaRx = '{en: 1'b1, d: b};
    last = b;
  endtask
  // preamble, sfd, n random bytes, fcs low byte first
  task automatic send_frame(input int n, input bit bad);
    logic [31:0] c;
    logic [7:0] b;
    c = CRC_INIT;
    for (int i = 0; i < 7; i++)
      put(PRE_BYTE);
    put(SFD_BYTE);
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      put(b);
      c = c ^ {24'h00_0000, b};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = ~c ^ {31'h0000_0000, bad};
    for (int i = 0; i < 4; i++)
      put(c[8*i +: 8]);
    @(negedge linkClk);
    // released line must not keep the last byte
    mediaRx = '{en: 1'b0, d: ~last};
  endtask
endmodule // ptg_link_partner
`default_nettype wire

// ==== verification/phy_test_loopback_packet_gen_test.sv ====
// self-checking bench of the test block
`timescale 1ns/1ns
`default_nettype none
module phy_test_loopback_packet_gen_test
  import ptg_pkg::*;
();
  logic clk, arst_n, wbCyc, wbStb, wbWe, wbAck, macRxOe, linkClk;
  logic linkOk, linkUp, anegEn, fullDuplex, connLoop, pairSwapOff, irq;
  logic [4:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  logic [1:0] speedSel;
  ptg_strm_type macTx, macRx, mediaRx, mediaTx;
  int num_errors, comparisons, n;
  logic [7:0] b;

  ptg_top #(.FRAME_LIMIT(3)) u_ptg_top (.clk(clk), .arst_n(arst_n),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .macTx(macTx), .macRx(macRx), .macRxOe(macRxOe), .linkClk(linkClk),
    .mediaRx(mediaRx), .linkOk(linkOk), .mediaTx(mediaTx),
    .linkUp(linkUp), .anegEn(anegEn), .speedSel(speedSel),
    .fullDuplex(fullDuplex), .connLoop(connLoop),
    .pairSwapOff(pairSwapOff), .irq(irq));
  ptg_link_partner u_ptg_link_partner (.linkClk(linkClk),
    .mediaRx(mediaRx), .linkOk(linkOk));

  always #5 clk = ~clk;

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, logic [4:0] a, logic [31:0] w);
    int k;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, a, 4'hF, w};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wbAck !== 1'b1 && k < 50);
    rd = wbDatR;
    {wbCyc, wbStb} <= 2'b00;
    if (k >= 50)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  // two link edges pass, so the newly selected path is in place
  task automatic ctl(input logic [31:0] v);
    wb(1'b1, OFF_CTRL, v);
    repeat (30) @(posedge clk);
  endtask
  // bounded wait for a byte on the media transmit side
  task automatic wait_tx();
    int k;
    for (k = 0; k < 400 && mediaTx.en !== 1'b1; k++)
      @(posedge clk);
    if (mediaTx.en !== 1'b1)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  initial
  begin
    rd = $urandom(32'hc2b96070);
    {clk, arst_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
    macTx = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    wb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk("ctrl", CTRL_RST, rd);
    wb(1'b0, OFF_GEN1, 32'h0000_0000);
    chk("gen1", GEN1_RST, rd);
    chk("rxoe", 32'h0000_0001, 32'(macRxOe));
    wb(1'b1, OFF_IMASK, 32'h0000_0007);
    // good then bad frame on the media side
    u_ptg_link_partner.send_frame(4 + $urandom % 8, 1'b0);
    repeat (30) @(posedge clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    wb(1'b0, OFF_GOOD, 32'h0000_0000);
    chk("good", 32'h0000_8001, rd);
    wb(1'b0, OFF_GOOD, 32'h0000_0000);
    chk("good clr", 32'h0000_0000, rd);
    wb(1'b0, OFF_ISTAT, 32'h0000_0000);
    chk("istat", 32'h0000_0001, rd);
    u_ptg_link_partner.send_frame(4 + $urandom % 8, 1'b1);
    repeat (30) @(posedge clk);
    wb(1'b0, OFF_BAD, 32'h0000_0000);
    chk("bad", 32'h0000_0001, rd);
    wb(1'b0, OFF_BAD, 32'h0000_0000);
    chk("bad clr", 32'h0000_0000, rd);
    wb(1'b0, OFF_GOOD, 32'h0000_0000);
    chk("flag", 32'h0000_8000, rd);
    // near loop: mac data returns, media stays quiet
    ctl(CTRL_RST | (32'h1 << B_NEAR));
    b = 8'($urandom);
    macTx <= '{en: 1'b1, d: b};
    repeat (40) @(posedge clk);
    chk("near rx", {23'h0, 1'b1, b}, 32'(macRx));
    chk("near tx", 32'h0000_0000, 32'(mediaTx.en));
    ctl(CTRL_RST | (32'h1 << B_ISOLATE));
    chk("isolate", 32'h0000_0000, 32'(macRxOe));
    // far loop with mac transmit still active
    ctl(CTRL_RST | (32'h1 << B_FAR));
    fork
      u_ptg_link_partner.send_frame(6, 1'b0);
      begin
        wait_tx();
        repeat (2) @(posedge clk);
        chk("far tx", 32'(PRE_BYTE), 32'(mediaTx.d));
        chk("far rx", 32'(PRE_BYTE), 32'(macRx.d));
      end
    join
    // generator run of three frames ends by itself; mac keeps sending
    wb(1'b1, OFF_GEN0, {16'h0000, 16'($urandom)});
    ctl(CTRL_RST | 32'h0000_0003);
    wait_tx();
    chk("gen pre", 32'(PRE_BYTE), 32'(mediaTx.d));
    chk("gen rxoe", 32'h0000_0001, 32'(macRxOe));
    wb(1'b0, OFF_STAT, 32'h0000_0000);
    chk("stat", 32'h0000_0003, rd);
    for (n = 0; n < 3000; n++)
    begin
      wb(1'b0, OFF_CTRL, 32'h0000_0000);
      if (rd[B_START] === 1'b0)
        break;
    end
    chk("start", 32'h0000_0000, 32'(rd[B_START]));
    if (rd[B_START] !== 1'b0)
      tally_and_finish();
    wb(1'b0, OFF_ISTAT, 32'h0000_0000);
    chk("done", 32'h0000_0002, rd & 32'h0000_0002);
    // continuous mode runs past the frame limit
    ctl(CTRL_RST | 32'h0000_0007);
    repeat (4000) @(posedge clk);
    wb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk("cont", 32'h0000_0002, rd & 32'h0000_0002);
    // diagnostics drop only a slower link
    ctl((CTRL_RST & 32'hFFFF_CBFF) | 32'h0000_1080);
    chk("speed", 32'h0000_0001, 32'(speedSel));
    chk("aneg dpx", 32'h0000_0001, {30'h0, anegEn, fullDuplex});
    chk("drop", 32'h0000_0000, 32'(linkUp));
    ctl((CTRL_RST & 32'hFFFF_CFFF) | 32'h0000_1000);
    chk("back", 32'h0000_0001, 32'(linkUp));
    ctl(CTRL_RST | 32'h0000_0080);
    chk("keep", 32'h0000_0001, 32'(linkUp));
    ctl(CTRL_RST | 32'h0000_0100);
    chk("conn", 32'h0000_0001, 32'(connLoop));
    ctl(CTRL_RST | 32'h0000_0300);
    chk("swap", 32'h0000_0001, 32'(pairSwapOff));
    tally_and_finish();
  end
endmodule // phy_test_loopback_packet_gen_test
`default_nettype wire
